// File: rsp_pkg.sv
// Purpose: Shared constants and types for the reset source and power-on sequencer.
// Assumes: 50 MHz system clock, classic Wishbone register access with 32-bit data.
// Notes:   Registers carry at most 8 bits of data in the low lane; upper bits read as zero.
package rsp_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int RSP_CLK_HZ = 50_000_000;
    localparam int RSP_POR_DELAY_LO_MS = 7;    // Typical release delay at low supply
    localparam int RSP_POR_DELAY_HI_MS = 15;   // Typical release delay at high supply
    localparam int RSP_MAX_RAMP_MS = 3;        // Slowest supply ramp the delay is valid for
    localparam int RSP_CNT_W = 24;
    localparam int RSP_RST_HOLD_CYC = 4;       // Hold for non power-on resets
    localparam int RSP_WDT_DIV = 12;
    localparam logic [3:0] RSP_WDT_DIV_LAST = 4'h0b;

    // Least time rounded up to whole cycles, at least one cycle
    function automatic int rsp_ms_to_cyc(input int ms);
        longint c;
        c = (longint'(ms) * longint'(RSP_CLK_HZ) + 999) / 1000;
        return (c < 1) ? 1 : int'(c);
    endfunction : rsp_ms_to_cyc

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] RSP_ADR_CAUSE = 8'h00;   // reset_cause_register
    localparam logic [7:0] RSP_ADR_PMODE = 8'h04;   // power_mgmt_mode_register
    localparam logic [7:0] RSP_ADR_IRQ_STS = 8'h08;
    localparam logic [7:0] RSP_ADR_IRQ_MSK = 8'h0c;
    localparam logic [7:0] RSP_ADR_WDT = 8'h10;

    // Cause, power mode, interrupt and watchdog register fields
    localparam int RSP_CAUSE_PIN = 0;
    localparam int RSP_CAUSE_POR = 1;              // power_on_cause_flag
    localparam int RSP_CAUSE_MON = 2;
    localparam int RSP_CAUSE_WDT = 3;
    localparam int RSP_CAUSE_SW = 4;               // Write one to request a reset
    localparam int RSP_PMODE_POR_MONITOR_DISABLE_BIT = 5;       // por_monitor_disable
    localparam int RSP_IRQ_DONE = 0;
    localparam int RSP_IRQ_DROP = 1;
    localparam int RSP_WDT_EN_BIT = 0;

    // Reset values
    localparam logic [7:0] RSP_CAUSE_RST = 8'h00;
    localparam logic [7:0] RSP_PMODE_RST = 8'h00;
    localparam logic [1:0] RSP_IRQ_RST = 2'h0;
    localparam logic [7:0] RSP_PORT_LATCH_RST = 8'hff;
    localparam logic [15:0] RSP_FETCH_ADDR_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rsp_wb_req_t;

    typedef struct packed {
        logic supply_above_por;   // power_on_threshold comparator, high when above
        logic supply_high;        // High end of supply range selects longer delay
        logic pin_low;            // External reset pin seen low
        logic supply_mon_low;     // Active mode supply monitor trip
        logic wdt_timeout;        // Watchdog expiry pulse
        logic sleep;              // Device in sleep mode
    } rsp_src_t;

    typedef enum logic [1:0] {
        RSP_ST_POR_HOLD,
        RSP_ST_POR_DELAY,
        RSP_ST_RST_HOLD,
        RSP_ST_RUN
    } rsp_state_t;

endpackage : rsp_pkg

// File: rsp_reset_sequencer.sv
// Purpose: Reset source capture and power-on release sequencing for a small controller.
// Assumes: All inputs synchronous to sys_clk_in; arst_n_in is the analog power-good reset.
// Notes:   The power_on_release_delay counter runs on sys_clk_in, which never stops here.
//
// Overview of operation
// - Entering reset halts the core, resets registers, fixes pins, stops interrupts and timers.
// - Data memory is never cleared by reset; writes are blocked while reset holds.
// - Stack pointer returns to default with the register reset; memory stays intact.
// - Port latches load all ones with pins in open-drain mode during reset.
// - Weak pull-ups are on during reset and stay on afterwards.
// - Monitor and power-on resets drive the external reset pin low until exit.
// - Reset exit clears the program counter; clock selects internal oscillator.
// - After reset the watchdog runs enabled, clocked at system clock over twelve.
// - Instruction fetch starts at address zero whatever caused the reset.
// - Hold reset during power-up, then wait a delay after passing the threshold.
// - Release delay is about 7 ms low supply, 15 ms high supply.
// - Power-on reset end sets the power-on flag, bit 1 of cause register.
// - Other flags are meaningless with the power-on flag; other resets clear it.
// - The power-on monitor stays active in sleep and resets on supply loss.
// - Writing one to mode bit 5 turns the power-on monitor off.
// - With the monitor off every reset runs a full power-on sequence and re-enables it.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rsp_reset_sequencer #(
    parameter int POR_DELAY_LO_CYC = rsp_pkg::rsp_ms_to_cyc(rsp_pkg::RSP_POR_DELAY_LO_MS),
    parameter int POR_DELAY_HI_CYC = rsp_pkg::rsp_ms_to_cyc(rsp_pkg::RSP_POR_DELAY_HI_MS),
    parameter int RST_HOLD_CYC = rsp_pkg::RSP_RST_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Register bus
    input wire rsp_pkg::rsp_wb_req_t wb_req_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Reset sources
    input wire rsp_pkg::rsp_src_t src_in,
    // Core and peripherals
    output logic sys_rst_n_out,
    output logic core_halt_out,
    output logic core_start_out,
    output logic pc_clear_out,
    output logic [15:0] fetch_addr_out,
    output logic ram_write_block_out,
    output logic clk_sel_internal_out,
    output logic wdt_enable_out,
    output logic wdt_tick_out,
    // Ports
    output logic port_force_out,
    output logic [7:0] port_latch_value_out,
    output logic port_open_drain_out,
    output logic weak_pullup_en_out,
    // External reset pin, drive low only
    output logic rst_pin_out,
    output logic rst_pin_oe_out,
    // Supply monitor and interrupt
    output logic por_monitor_on_out,
    output logic irq_out
);
    import rsp_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (POR_DELAY_LO_CYC < 1 || POR_DELAY_HI_CYC < 1 || RST_HOLD_CYC < 1 ||
        POR_DELAY_LO_CYC >= (1 << RSP_CNT_W) || POR_DELAY_HI_CYC >= (1 << RSP_CNT_W) ||
        RST_HOLD_CYC >= (1 << RSP_CNT_W)) begin : g_chk_cnt
        $error("a delay or hold count does not fit the counter");
    end

    localparam logic [RSP_CNT_W-1:0] DLY_LO = RSP_CNT_W'(POR_DELAY_LO_CYC);
    localparam logic [RSP_CNT_W-1:0] DLY_HI = RSP_CNT_W'(POR_DELAY_HI_CYC);
    localparam logic [RSP_CNT_W-1:0] HOLD_CNT = RSP_CNT_W'(RST_HOLD_CYC);
    localparam logic [RSP_CNT_W-1:0] CNT_ONE = RSP_CNT_W'(1);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    rsp_state_t state_reg, state_next;
    logic [RSP_CNT_W-1:0] cnt_reg, cnt_next;
    logic [7:0] cause_reg;
    logic [7:0] pmode_reg;
    logic [1:0] irq_sts_reg;
    logic [1:0] irq_msk_reg;
    logic wdt_en_reg;
    logic [3:0] wdt_div_reg;
    logic sw_req_reg;
    logic mon_drive_reg;
    logic mon_drive_next;
    logic [31:0] rd_dat;
    logic bus_hit;
    logic bus_wr;
    logic mon_disabled;
    logic por_req;
    logic other_req;
    logic in_reset_next;
    logic exit_pulse;
    logic entry_other;
    logic por_done;

    // Bus access is taken on the first cycle of a request only
    assign bus_hit = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
    assign bus_wr = bus_hit && wb_req_in.we && wb_req_in.sel[0];

    assign mon_disabled = pmode_reg[RSP_PMODE_POR_MONITOR_DISABLE_BIT];
    // Monitor keeps watching in sleep; only the disable bit silences it
    assign por_req = !src_in.supply_above_por && !mon_disabled;
    assign other_req = src_in.pin_low || src_in.supply_mon_low || src_in.wdt_timeout || sw_req_reg;

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    // One counter serves both the power-on delay and the short reset hold
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            RSP_ST_POR_HOLD: begin
                // Stay in reset until the supply passes the threshold
                if (src_in.supply_above_por) begin
                    state_next = RSP_ST_POR_DELAY;
                    cnt_next = src_in.supply_high ? DLY_HI : DLY_LO;
                end
            end
            RSP_ST_POR_DELAY: begin
                if (!src_in.supply_above_por) begin
                    state_next = RSP_ST_POR_HOLD;
                end else if (cnt_reg <= CNT_ONE) begin
                    state_next = RSP_ST_RUN;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            RSP_ST_RST_HOLD: begin
                if (por_req) begin
                    state_next = RSP_ST_POR_HOLD;
                end else if (src_in.pin_low || src_in.supply_mon_low) begin
                    // Source still active: keep holding and restart the count
                    cnt_next = HOLD_CNT;
                end else if (cnt_reg <= CNT_ONE) begin
                    state_next = RSP_ST_RUN;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            RSP_ST_RUN: begin
                if (por_req) begin
                    state_next = RSP_ST_POR_HOLD;
                end else if (other_req && mon_disabled) begin
                    // Any source becomes a full power-on sequence
                    state_next = RSP_ST_POR_HOLD;
                end else if (other_req) begin
                    state_next = RSP_ST_RST_HOLD;
                    cnt_next = HOLD_CNT;
                end
            end
            default: begin
                state_next = RSP_ST_POR_HOLD;
            end
        endcase
    end

    assign in_reset_next = (state_next != RSP_ST_RUN);
    assign exit_pulse = (state_reg != RSP_ST_RUN) && (state_next == RSP_ST_RUN);
    assign entry_other = (state_reg == RSP_ST_RUN) && (state_next == RSP_ST_RST_HOLD);
    assign por_done = (state_reg == RSP_ST_POR_DELAY) && (state_next == RSP_ST_RUN);
    // Pin drive follows the next state, so it starts in the first reset cycle
    assign mon_drive_next = (state_next == RSP_ST_POR_HOLD || state_next == RSP_ST_POR_DELAY) ? 1'b1 :
                            entry_other ? src_in.supply_mon_low :
                            (state_next == RSP_ST_RUN) ? 1'b0 : mon_drive_reg;

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    // Power-up always begins in the threshold wait
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= RSP_ST_POR_HOLD;
            cnt_reg <= '0;
            mon_drive_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            mon_drive_reg <= mon_drive_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs towards core, ports and pin
    // ----------------------------------------------------------------
    // Asserted at once by arst, released only on a clock edge, so every
    // register behind sys_rst_n_out leaves reset in the same cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sys_rst_n_out <= 1'b0;
            core_halt_out <= 1'b1;
            ram_write_block_out <= 1'b1;
            port_force_out <= 1'b1;
            clk_sel_internal_out <= 1'b1;
            rst_pin_out <= 1'b0;
            rst_pin_oe_out <= 1'b1;
        end else begin
            // Register, stack pointer, interrupt and timer reset in one line
            sys_rst_n_out <= !in_reset_next;
            core_halt_out <= in_reset_next;
            // Memory is only guarded, never cleared, so it keeps its data
            ram_write_block_out <= in_reset_next;
            port_force_out <= in_reset_next;
            clk_sel_internal_out <= in_reset_next;
            rst_pin_out <= 1'b0;
            rst_pin_oe_out <= in_reset_next && mon_drive_next;
        end
    end

    // Constant reset values handed to the port and fetch logic
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_latch_value_out <= RSP_PORT_LATCH_RST;
            port_open_drain_out <= 1'b1;
            weak_pullup_en_out <= 1'b1;
            fetch_addr_out <= RSP_FETCH_ADDR_RST;
        end else begin
            port_latch_value_out <= RSP_PORT_LATCH_RST;
            port_open_drain_out <= 1'b1;
            // Pull-ups stay on after release; port logic may turn them off later
            weak_pullup_en_out <= 1'b1;
            fetch_addr_out <= RSP_FETCH_ADDR_RST;
        end
    end

    // One-cycle strobes at release; the same address for every cause
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_clear_out <= 1'b0;
            core_start_out <= 1'b0;
        end else begin
            pc_clear_out <= exit_pulse;
            core_start_out <= exit_pulse;
        end
    end

    // ----------------------------------------------------------------
    // Cause register
    // ----------------------------------------------------------------
    // Other flags are zeroed at power-on since they carry no meaning then
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cause_reg <= RSP_CAUSE_RST;
        end else if (por_done) begin
            cause_reg <= RSP_CAUSE_RST;
            cause_reg[RSP_CAUSE_POR] <= 1'b1;
        end else if (entry_other) begin
            cause_reg <= RSP_CAUSE_RST;
            cause_reg[RSP_CAUSE_PIN] <= src_in.pin_low;
            cause_reg[RSP_CAUSE_MON] <= src_in.supply_mon_low;
            cause_reg[RSP_CAUSE_WDT] <= src_in.wdt_timeout;
            cause_reg[RSP_CAUSE_SW] <= sw_req_reg;
        end
    end

    // Software reset request, taken by the sequencer one cycle later
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sw_req_reg <= 1'b0;
        end else if (bus_wr && wb_req_in.adr == RSP_ADR_CAUSE && wb_req_in.dat[RSP_CAUSE_SW]) begin
            sw_req_reg <= (state_reg == RSP_ST_RUN);
        end else if (state_reg != RSP_ST_RUN) begin
            sw_req_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Power mode register
    // ----------------------------------------------------------------
    // Every reset restores the default, so the monitor comes back on
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pmode_reg <= RSP_PMODE_RST;
        end else if (state_next != RSP_ST_RUN) begin
            pmode_reg <= RSP_PMODE_RST;
        end else if (bus_wr && wb_req_in.adr == RSP_ADR_PMODE) begin
            pmode_reg <= wb_req_in.dat[7:0];
        end
    end

    // Analog side sees the monitor state from the register, a write in this cycle included
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            por_monitor_on_out <= 1'b1;
        end else if (state_next != RSP_ST_RUN) begin
            por_monitor_on_out <= 1'b1;
        end else if (bus_wr && wb_req_in.adr == RSP_ADR_PMODE) begin
            por_monitor_on_out <= !wb_req_in.dat[RSP_PMODE_POR_MONITOR_DISABLE_BIT];
        end else begin
            por_monitor_on_out <= !mon_disabled;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog default and divide-by-twelve tick
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdt_en_reg <= 1'b0;
        end else if (state_next != RSP_ST_RUN) begin
            wdt_en_reg <= 1'b1;
        end else if (bus_wr && wb_req_in.adr == RSP_ADR_WDT) begin
            wdt_en_reg <= wb_req_in.dat[RSP_WDT_EN_BIT];
        end
    end

    // Tick every twelfth clock while running with the watchdog on
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdt_div_reg <= 4'h0;
            wdt_tick_out <= 1'b0;
            wdt_enable_out <= 1'b0;
        end else begin
            // Gated by the next state, so no tick lands in the first reset cycle
            wdt_enable_out <= wdt_en_reg && (state_next == RSP_ST_RUN);
            wdt_tick_out <= 1'b0;
            if (state_next != RSP_ST_RUN || !wdt_en_reg) begin
                wdt_div_reg <= 4'h0;
            end else if (wdt_div_reg == RSP_WDT_DIV_LAST) begin
                wdt_div_reg <= 4'h0;
                wdt_tick_out <= 1'b1;
            end else begin
                wdt_div_reg <= wdt_div_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------
    // Hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_sts_reg <= RSP_IRQ_RST;
        end else begin
            irq_sts_reg <= (irq_sts_reg & ~((bus_wr && wb_req_in.adr == RSP_ADR_IRQ_STS) ?
                            wb_req_in.dat[1:0] : 2'h0))
                           | {src_in.supply_mon_low, exit_pulse};
        end
    end

    // Mask is cleared by every reset, so interrupts start disabled
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_msk_reg <= RSP_IRQ_RST;
            irq_out <= 1'b0;
        end else begin
            if (state_next != RSP_ST_RUN) begin
                irq_msk_reg <= RSP_IRQ_RST;
            end else if (bus_wr && wb_req_in.adr == RSP_ADR_IRQ_MSK) begin
                irq_msk_reg <= wb_req_in.dat[1:0];
            end
            irq_out <= |(irq_sts_reg & irq_msk_reg);
        end
    end

    // ----------------------------------------------------------------
    // Wishbone read path and acknowledge
    // ----------------------------------------------------------------
    always_comb begin
        rd_dat = 32'h0000_0000;
        case (wb_req_in.adr)
            RSP_ADR_CAUSE: rd_dat[7:0] = cause_reg;
            RSP_ADR_PMODE: rd_dat[7:0] = pmode_reg;
            RSP_ADR_IRQ_STS: rd_dat[1:0] = irq_sts_reg;
            RSP_ADR_IRQ_MSK: rd_dat[1:0] = irq_msk_reg;
            RSP_ADR_WDT: rd_dat[RSP_WDT_EN_BIT] = wdt_en_reg;
            default: rd_dat = 32'h0000_0000;
        endcase
    end

    // Ack one cycle after the strobe; unmapped addresses read zero and ack
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_hit;
            if (bus_hit && !wb_req_in.we) begin
                wb_dat_out <= rd_dat;
            end
        end
    end

endmodule : rsp_reset_sequencer

`default_nettype wire

// File: rsp_seq_assertions.sv
// Purpose: Port checks for the reset sequencer
// Assumes: One clock, reset arst_n_in
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rsp_seq_assertions (
    // Clock, reset and bus
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire rsp_pkg::rsp_wb_req_t wb_req_in,
    input wire logic wb_ack_out,
    // Sequencer outputs
    input wire logic sys_rst_n_out,
    input wire logic core_halt_out,
    input wire logic pc_clear_out,
    input wire logic [7:0] port_latch_value_out,
    input wire logic rst_pin_oe_out,
    input wire logic wdt_tick_out,
    input wire logic por_monitor_on_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Bus answers in the next cycle, for one cycle only
    a_ack_next: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_ack_out |=> wb_ack_out) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    // Core and timers stay stopped while in reset
    a_halt_reset: assert property (!sys_rst_n_out |-> core_halt_out && !wdt_tick_out) else $error("core runs");
    a_latch_ones: assert property (port_latch_value_out == 8'hff) else $error("latch");
    // Pin drive outside reset would hold the board in reset
    a_pin_in_reset: assert property (rst_pin_oe_out |-> !sys_rst_n_out) else $error("pin drive");
    a_start_clear: assert property ($rose(sys_rst_n_out) |-> pc_clear_out ##1 !pc_clear_out) else $error("pc");
    // Period is twelve, so eleven quiet cycles follow each tick; the check asks for only eight of them
    a_tick_gap: assert property (wdt_tick_out |=> !wdt_tick_out [*8]) else $error("tick gap");
    a_mon_reenable: assert property ($rose(sys_rst_n_out) |-> por_monitor_on_out) else $error("monitor");
    cover property ($rose(sys_rst_n_out));
    cover property (wdt_tick_out);
    cover property (!sys_rst_n_out && rst_pin_oe_out);
endmodule : rsp_seq_assertions
bind rsp_reset_sequencer rsp_seq_assertions u_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out), .sys_rst_n_out(sys_rst_n_out), .core_halt_out(core_halt_out),
    .pc_clear_out(pc_clear_out), .port_latch_value_out(port_latch_value_out), .rst_pin_oe_out(rst_pin_oe_out),
    .wdt_tick_out(wdt_tick_out), .por_monitor_on_out(por_monitor_on_out));
`default_nettype wire

// File: rsp_src_model.sv
// Purpose: Supply comparators, reset pin and watchdog facing the sequencer
// Assumes: Levels set by the bench in step with sys_clk_in
// Notes: Comparators are combinational, so they add no latency
`timescale 1ns/1ps
`default_nettype none
module rsp_src_model (
    // Analog and event levels
    input wire logic vdd_ok_in,
    input wire logic vdd_hi_in,
    input wire logic pin_in,
    input wire logic wdt_in,
    input wire logic mon_low_in,
    input wire logic sleep_in,
    // To the sequencer
    output rsp_pkg::rsp_src_t src_out
);
    // Sleep does not gate the threshold comparator, it keeps watching
    assign src_out = '{vdd_ok_in, vdd_hi_in, pin_in, mon_low_in, wdt_in, sleep_in};
endmodule : rsp_src_model
`default_nettype wire

// File: tb_reset_source_por_sequencer.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Delays shortened to 20 and 40 cycles
// Notes: Register reads after power-up run from a table
`timescale 1ns/1ps
`default_nettype none
module tb_reset_source_por_sequencer;
    import rsp_pkg::*;
    localparam int LO = 20;
    localparam int HI = 40;
    logic clk, rst_n, ok, hi, pin, wdt, slp, sml, ack, srn, oe, mon, irq;
    logic [31:0] rd, q;
    rsp_wb_req_t req;
    rsp_src_t src;
    logic [15:0] rows [6] = '{16'h0002, 16'h0400, 16'h0801, 16'h0c00, 16'h1001, 16'h1400};
    int n_fail = 0;
    int n_compared = 0;
    int n;
    rsp_src_model model (.vdd_ok_in(ok), .vdd_hi_in(hi), .pin_in(pin), .wdt_in(wdt), .mon_low_in(sml),
        .sleep_in(slp), .src_out(src));
    rsp_reset_sequencer #(.POR_DELAY_LO_CYC(LO), .POR_DELAY_HI_CYC(HI), .RST_HOLD_CYC(4)) dut (.sys_clk_in(clk),
        .arst_n_in(rst_n), .wb_req_in(req), .wb_dat_out(rd), .wb_ack_out(ack), .src_in(src), .sys_rst_n_out(srn),
        .core_halt_out(), .core_start_out(), .pc_clear_out(), .fetch_addr_out(), .ram_write_block_out(),
        .clk_sel_internal_out(), .wdt_enable_out(), .wdt_tick_out(), .port_force_out(), .port_latch_value_out(),
        .port_open_drain_out(), .weak_pullup_en_out(), .rst_pin_out(), .rst_pin_oe_out(oe), .por_monitor_on_out(mon),
        .irq_out(irq));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
        if (got !== exp) n_fail++;
    endtask : chk
    // Classic cycle, held until ack is sampled at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h00_0000, d}};
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        req <= '0;
    endtask : wb
    // Falling edges until the core leaves reset; only the watchdog ends a hang
    task automatic wrel();
        for (n = 0; srn !== 1'b1; n++) @(negedge clk);
    endtask : wrel
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run is a few hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        {rst_n, ok, hi, pin, wdt, slp, sml} = '0;
        req = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        chk({srn, oe, mon}, 3'b011);
        @(posedge clk);
        ok <= 1'b1;
        wrel();
        chk(n inside {[LO + 1:LO + 2]}, 1'b1);
        $display("power-up done");
        // Data memory is never read back after power-up, it counts as undefined
        foreach (rows[k]) wb(1'b0, rows[k][15:8], 8'h00);
        foreach (rows[k]) chk(rd !== 'x, 1'b1);
        for (int k = 0; k < 6; k++) begin
            wb(1'b0, rows[k][15:8], 8'h00);
            chk(q, {24'h00_0000, rows[k][7:0]});
        end
        $display("table done");
        chk(irq, 1'b0);
        wb(1'b1, 8'h0c, 8'h01);
        repeat (2) @(negedge clk);
        chk(irq, 1'b1);
        wb(1'b1, 8'h08, 8'h01);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        $display("irq done");
        @(posedge clk);
        {ok, hi, slp} <= 3'b011;
        repeat (3) @(negedge clk);
        chk({srn, oe}, 2'b01);
        @(posedge clk);
        ok <= 1'b1;
        wrel();
        chk(n inside {[HI + 1:HI + 2]}, 1'b1);
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        @(negedge clk);
        chk({srn, oe}, 2'b00);
        wrel();
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'h0000_0008);
        $display("watchdog done");
        wb(1'b1, 8'h00, 8'h10);
        @(negedge clk);
        chk({srn, oe}, 2'b00);
        wrel();
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'h0000_0010);
        @(posedge clk);
        sml <= 1'b1;
        @(posedge clk);
        sml <= 1'b0;
        @(negedge clk);
        chk({srn, oe}, 2'b01);
        wrel();
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'h0000_0004);
        $display("software and monitor trip done");
        wb(1'b1, 8'h04, 8'h20);
        @(negedge clk);
        chk(mon, 1'b0);
        @(posedge clk);
        pin <= 1'b1;
        @(posedge clk);
        pin <= 1'b0;
        @(negedge clk);
        wrel();
        chk(n inside {[HI + 1:HI + 2]}, 1'b1);
        wb(1'b0, 8'h04, 8'h00);
        chk({q[7:0], mon}, 9'h001);
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'h0000_0002);
        $display("monitor off done");
        print_verdict();
    end
endmodule : tb_reset_source_por_sequencer
`default_nettype wire
